//--- logic/rmmc_pkg.sv
// Shared constants, types and CRC step for the radio modem mode controller
package rmmc_pkg;
  localparam int          LEN_W          = 12;
  localparam int          HDR_LEN        = 5;
  localparam int          CLK_HZ         = 100_000_000;
  localparam int          CHAR_BITS      = 10;
  localparam int          BAUD_DEF       = 115_200;
  localparam int          CHAR_CYC_DEF   = CLK_HZ / BAUD_DEF * CHAR_BITS;
  localparam int          CTS_RESUME     = 34;
  localparam int          DI_DEPTH_DEF   = 2048;
  localparam int          DO_DEPTH_DEF   = 2048;

  localparam logic [7:0]  OFF_THR        = 8'h00;
  localparam logic [7:0]  OFF_TOUT       = 8'h04;
  localparam logic [7:0]  OFF_MAXPKT     = 8'h08;
  localparam logic [7:0]  OFF_NETID      = 8'h0C;
  localparam logic [7:0]  OFF_HOPCH      = 8'h10;
  localparam logic [7:0]  OFF_DSTADDR    = 8'h14;
  localparam logic [7:0]  OFF_FLOW       = 8'h18;
  localparam logic [7:0]  OFF_STATUS     = 8'h1C;
  localparam logic [7:0]  OFF_DROPS      = 8'h20;

  localparam logic [11:0] THR_RST        = 12'h800;
  localparam logic [15:0] TOUT_RST       = 16'h0003;
  localparam logic [11:0] MAXPKT_RST     = 12'h800;
  localparam logic [15:0] NETID_RST      = 16'h0000;
  localparam logic [7:0]  HOPCH_RST      = 8'h00;
  localparam logic [15:0] DSTADDR_RST    = 16'hFFFF;
  localparam logic [11:0] FLOW_RST       = 12'h011;

  localparam logic [15:0] CRC_INIT       = 16'hFFFF;
  localparam logic [15:0] CRC_POLY       = 16'h1021;

  typedef enum logic [1:0] {
    KIND_INIT = 2'h0,
    KIND_HDR  = 2'h1,
    KIND_PAY  = 2'h2,
    KIND_CRC  = 2'h3
  } rmmc_kind_t;

  typedef enum logic [6:0] {
    ST_IDLE   = 7'h01,
    ST_TXINIT = 7'h02,
    ST_TXHDR  = 7'h04,
    ST_TXPAY  = 7'h08,
    ST_TXCRC  = 7'h10,
    ST_RX     = 7'h20,
    ST_SHUT   = 7'h40
  } rmmc_state_t;

  function automatic logic [15:0] crcStep(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {d, 8'h00};
    for (int i = 0; i < 8; i++) begin
      r = r[15] ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction
endpackage

//--- logic/rmmc_crc_if.sv
// Byte stream into a CRC engine and its running value
interface rmmc_crc_if;
  logic        clear;
  logic        en;
  logic [7:0]  data;
  logic [15:0] crc;
  modport user   (output clear, output en, output data, input crc);
  modport engine (input clear, input en, input data, output crc);
endinterface

//--- logic/rmmc_crc16.sv
// Running 16-bit CRC over a byte stream
module rmmc_crc16
  import rmmc_pkg::*;
(
  input wire logic    clk,
  input wire logic    rst,
  rmmc_crc_if.engine  bus
);
  logic [15:0] crc_r;

  // Clear wins so a new packet can start on the cycle after the last byte
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      crc_r <= CRC_INIT;
    end else if (bus.clear) begin
      crc_r <= CRC_INIT;
    end else if (bus.en) begin
      crc_r <= crcStep(crc_r, bus.data);
    end
  end

  assign bus.crc = crc_r;
endmodule

//--- logic/rmmc_mode_ctrl.sv
// Mode controller: idle, transmit framing, receive filtering, shutdown
// Function
// - Sit idle when not sending or receiving; leave on the matching trigger.
// - Return to idle by itself after handling any mode trigger.
// - First buffered serial byte starts a transmit attempt; back to idle when done (code starts only on the threshold or silence trigger).
// - Start sending once pending bytes reach the byte threshold.
// - Also start after configured silent character times with a byte pending.
// - Silence timeout of zero disables that trigger; only the threshold remains.
// - Never enter transmit while a reception is in progress.
// - Split buffered data into packets of at most maximum size until empty.
// - Keep storing serial bytes during channel initialization.
// - Near packet end check the input buffer and send another packet if non-empty.
// - When streaming, only the first packet carries the initializer.
// - Every new connection begins with an initializer carrying channel information.
// - Accept received packets only when channel, network id and destination match.
// - Append a 16-bit CRC over the sent data to every packet.
// - Recompute CRC on receive; drop mismatches, pass good packets to output buffer.
// - Leave receive when radio data stops or an error is seen.
// - Serial bytes arriving during receive are held and sent afterwards.
// - Low shutdown input forces shutdown at once, aborting traffic and discarding buffers.
// - Rising shutdown edge resets the controller; host waits before expecting operation.
// - In shutdown the indicator, serial and flow pins float; shutdown line driven low.
// - Deassert clear-to-send when the input buffer is within threshold bytes of full.
// - Reassert clear-to-send once 34 bytes are free again.
// - Radio data arriving with a full output buffer is dropped.
//
// The register addresses and register access over APB were left to the implementer.
module rmmc_mode_ctrl
  import rmmc_pkg::*;
#(
  parameter int DI_DEPTH    = rmmc_pkg::DI_DEPTH_DEF,
  parameter int DO_DEPTH    = rmmc_pkg::DO_DEPTH_DEF,
  parameter int CHAR_CYCLES = rmmc_pkg::CHAR_CYC_DEF
)(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              serialInValid,
  input  wire logic [7:0]        serialInData,
  output logic                   serialOutValid,
  output logic      [7:0]        serialOutData,
  input  wire logic              serialOutReady,
  output logic                   txValid,
  output logic      [7:0]        txData,
  output rmmc_pkg::rmmc_kind_t   txKind,
  input  wire logic              txReady,
  input  wire logic              rxActive,
  input  wire logic              rxByteValid,
  input  wire logic [7:0]        rxByteData,
  input  wire logic              rxByteLast,
  input  wire logic              rxError,
  input  wire logic              shutdownN,
  output logic                   shutLineOut,
  output logic                   shutLineOe,
  output logic                   ctsN,
  output logic                   ctsOe,
  output logic                   carrierDetectOut,
  output logic                   carrierDetectOe,
  output logic                   transmitPowerOut,
  output logic                   transmitPowerOe,
  output logic                   receiveIndicatorOut,
  output logic                   receiveIndicatorOe,
  output logic                   serialOutOe
);
  import rmmc_pkg::*;

  localparam int DIW = $clog2(DI_DEPTH);
  localparam int DOW = $clog2(DO_DEPTH);

  rmmc_crc_if txCrc ();
  rmmc_crc_if rxCrc ();
  rmmc_crc16 uTxCrc (.clk(clk), .rst(rst), .bus(txCrc));
  rmmc_crc16 uRxCrc (.clk(clk), .rst(rst), .bus(rxCrc));

  logic [7:0]      diMem [DI_DEPTH];
  logic [7:0]      doMem [DO_DEPTH];
  logic [DIW:0]    diWr_r, diRd_r, diCount;
  logic [DOW:0]    doWr_r, doCommit_r, doRd_r, doUsed;
  logic            sdnMeta_r, sdnSync_r, shut;
  rmmc_state_t     state_r;
  logic [11:0]     thr_r, maxPkt_r, flowThr_r;
  logic [15:0]     tout_r, netId_r, dstAddr_r, crcDrops_r, filtDrops_r;
  logic [7:0]      hopCh_r;
  logic [15:0]     cycCnt_r, chars_r;
  logic [11:0]     pktLeft_r;
  logic [2:0]      hdrIdx_r;
  logic            crcIdx_r;
  logic [11:0]     rxIdx_r;
  logic            hdrBad_r, rxOvf_r;
  logic            canSend, countHit, timeoutHit, crcLastEmit, doFull, rxGood;
  int              diFree;

  function automatic logic [7:0] hdrByte(input logic [2:0] idx, input logic [7:0] ch,
                                         input logic [15:0] nid, input logic [15:0] dst);
    case (idx)
      3'h0:    return ch;
      3'h1:    return nid[15:8];
      3'h2:    return nid[7:0];
      3'h3:    return dst[15:8];
      default: return dst[7:0];
    endcase
  endfunction

  function automatic logic regHit(input logic [7:0] a);
    return a == OFF_THR || a == OFF_TOUT || a == OFF_MAXPKT || a == OFF_NETID || a == OFF_HOPCH ||
           a == OFF_DSTADDR || a == OFF_FLOW || a == OFF_STATUS || a == OFF_DROPS;
  endfunction

  // Pin crosses in from the host, so two flops before use
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sdnMeta_r <= 1'b1;
      sdnSync_r <= 1'b1;
    end else begin
      sdnMeta_r <= shutdownN;
      sdnSync_r <= sdnMeta_r;
    end
  end
  assign shut = ~sdnSync_r;

  assign diCount    = diWr_r - diRd_r;
  assign doUsed     = doWr_r - doRd_r;
  assign doFull     = int'(doUsed) >= DO_DEPTH;
  assign diFree     = DI_DEPTH - int'(diCount);
  assign canSend    = ~txValid | txReady;
  assign countHit   = diCount != '0 && int'(diCount) >= int'(thr_r);
  assign timeoutHit = tout_r != '0 && diCount != '0 && chars_r >= tout_r;
  assign crcLastEmit = state_r == ST_TXCRC && canSend && crcIdx_r;
  assign rxGood     = crcStep(rxCrc.crc, rxByteData) == 16'h0000 && !hdrBad_r && !rxOvf_r && !doFull &&
                      int'(rxIdx_r) >= HDR_LEN + 2;

  // APB: one wait-free access, answer registered during setup
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~regHit(paddr);
      if (psel && !penable) begin
        case (paddr)
          OFF_THR:     prdata <= {20'h00000, thr_r};
          OFF_TOUT:    prdata <= {16'h0000, tout_r};
          OFF_MAXPKT:  prdata <= {20'h00000, maxPkt_r};
          OFF_NETID:   prdata <= {16'h0000, netId_r};
          OFF_HOPCH:   prdata <= {24'h000000, hopCh_r};
          OFF_DSTADDR: prdata <= {16'h0000, dstAddr_r};
          OFF_FLOW:    prdata <= {20'h00000, flowThr_r};
          OFF_STATUS:  prdata <= {1'b0, state_r, 12'(doUsed), 12'(diCount)};
          OFF_DROPS:   prdata <= {filtDrops_r, crcDrops_r};
          default:     prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      thr_r     <= THR_RST;
      tout_r    <= TOUT_RST;
      maxPkt_r  <= MAXPKT_RST;
      netId_r   <= NETID_RST;
      hopCh_r   <= HOPCH_RST;
      dstAddr_r <= DSTADDR_RST;
      flowThr_r <= FLOW_RST;
    end else if (psel && penable && pready && pwrite) begin
      case (paddr)
        OFF_THR:     thr_r     <= pwdata[11:0];
        OFF_TOUT:    tout_r    <= pwdata[15:0];
        OFF_MAXPKT:  maxPkt_r  <= pwdata[11:0];
        OFF_NETID:   netId_r   <= pwdata[15:0];
        OFF_HOPCH:   hopCh_r   <= pwdata[7:0];
        OFF_DSTADDR: dstAddr_r <= pwdata[15:0];
        OFF_FLOW:    flowThr_r <= pwdata[11:0];
        default:     ;
      endcase
    end
  end

  // Input buffer fills in every mode but shutdown, including init and receive
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      diWr_r <= '0;
    end else if (shut) begin
      diWr_r <= '0;
    end else if (serialInValid && int'(diCount) < DI_DEPTH) begin
      diWr_r <= diWr_r + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (serialInValid && !shut && int'(diCount) < DI_DEPTH) begin
      diMem[diWr_r[DIW-1:0]] <= serialInData;
    end
  end

  // Silence measured in character times since the last serial byte
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cycCnt_r <= '0;
      chars_r  <= '0;
    end else if (shut || serialInValid) begin
      cycCnt_r <= '0;
      chars_r  <= '0;
    end else if (int'(cycCnt_r) >= CHAR_CYCLES - 1) begin
      cycCnt_r <= '0;
      if (chars_r != 16'hFFFF) begin
        chars_r <= chars_r + 16'h0001;
      end
    end else begin
      cycCnt_r <= cycCnt_r + 16'h0001;
    end
  end

  // CRC feeds: clear between packets, accumulate header and payload
  always_comb begin
    txCrc.clear = state_r == ST_IDLE || state_r == ST_TXINIT || state_r == ST_SHUT || crcLastEmit;
    txCrc.en    = canSend && (state_r == ST_TXHDR || state_r == ST_TXPAY);
    txCrc.data  = state_r == ST_TXHDR ? hdrByte(hdrIdx_r, hopCh_r, netId_r, dstAddr_r)
                                      : diMem[diRd_r[DIW-1:0]];
    rxCrc.clear = state_r != ST_RX || (rxByteValid && rxByteLast);
    rxCrc.en    = state_r == ST_RX && rxByteValid;
    rxCrc.data  = rxByteData;
  end

  // Main sequencer: framing on the way out, filtering on the way in
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r     <= ST_IDLE;
      diRd_r      <= '0;
      doWr_r      <= '0;
      doCommit_r  <= '0;
      txValid     <= 1'b0;
      txData      <= 8'h00;
      txKind      <= KIND_INIT;
      hdrIdx_r    <= '0;
      crcIdx_r    <= 1'b0;
      pktLeft_r   <= '0;
      rxIdx_r     <= '0;
      hdrBad_r    <= 1'b0;
      rxOvf_r     <= 1'b0;
      crcDrops_r  <= '0;
      filtDrops_r <= '0;
    end else if (shut) begin
      state_r    <= ST_SHUT;
      diRd_r     <= '0;
      doWr_r     <= '0;
      doCommit_r <= '0;
      txValid    <= 1'b0;
      rxIdx_r    <= '0;
      hdrBad_r   <= 1'b0;
      rxOvf_r    <= 1'b0;
    end else begin
      if (txReady) begin
        txValid <= 1'b0;
      end
      case (state_r)
        ST_SHUT: begin
          state_r <= ST_IDLE;
        end
        ST_IDLE: begin
          if (rxActive) begin
            state_r <= ST_RX;
          end else if (countHit || timeoutHit) begin
            state_r <= ST_TXINIT;
          end
        end
        ST_TXINIT: begin
          if (canSend) begin
            txValid  <= 1'b1;
            txData   <= hopCh_r;
            txKind   <= KIND_INIT;
            hdrIdx_r <= '0;
            state_r  <= ST_TXHDR;
          end
        end
        ST_TXHDR: begin
          if (canSend) begin
            txValid  <= 1'b1;
            txData   <= hdrByte(hdrIdx_r, hopCh_r, netId_r, dstAddr_r);
            txKind   <= KIND_HDR;
            hdrIdx_r <= hdrIdx_r + 3'h1;
            if (int'(hdrIdx_r) == HDR_LEN - 1) begin
              // Size fixed here; bytes arriving later go in the next packet
              pktLeft_r <= int'(diCount) > int'(maxPkt_r) ? maxPkt_r : 12'(diCount);
              state_r   <= ST_TXPAY;
            end
          end
        end
        ST_TXPAY: begin
          if (canSend) begin
            txValid   <= 1'b1;
            txData    <= diMem[diRd_r[DIW-1:0]];
            txKind    <= KIND_PAY;
            diRd_r    <= diRd_r + 1'b1;
            pktLeft_r <= pktLeft_r - 12'h001;
            crcIdx_r  <= 1'b0;
            if (pktLeft_r == 12'h001) begin
              state_r <= ST_TXCRC;
            end
          end
        end
        ST_TXCRC: begin
          if (canSend) begin
            txValid  <= 1'b1;
            txData   <= crcIdx_r ? txCrc.crc[7:0] : txCrc.crc[15:8];
            txKind   <= KIND_CRC;
            crcIdx_r <= 1'b1;
            if (crcIdx_r) begin
              hdrIdx_r <= '0;
              state_r  <= diCount != '0 ? ST_TXHDR : ST_IDLE;
            end
          end
        end
        ST_RX: begin
          if (rxError || !rxActive) begin
            state_r  <= ST_IDLE;
            doWr_r   <= doCommit_r;
            rxIdx_r  <= '0;
            hdrBad_r <= 1'b0;
            rxOvf_r  <= 1'b0;
          end else if (rxByteValid) begin
            rxIdx_r <= rxIdx_r + 12'h001;
            if (int'(rxIdx_r) < HDR_LEN) begin
              if (rxByteData != hdrByte(3'(rxIdx_r), hopCh_r, netId_r, dstAddr_r)) begin
                hdrBad_r <= 1'b1;
              end
            end else if (doFull) begin
              rxOvf_r <= 1'b1;
            end else begin
              doWr_r <= doWr_r + 1'b1;
            end
            if (rxByteLast) begin
              rxIdx_r  <= '0;
              hdrBad_r <= 1'b0;
              rxOvf_r  <= 1'b0;
              if (rxGood) begin
                // Step back over the two CRC bytes just stored
                doWr_r     <= doWr_r - 1'b1;
                doCommit_r <= doWr_r - 1'b1;
              end else begin
                doWr_r <= doCommit_r;
                if (hdrBad_r) begin
                  filtDrops_r <= filtDrops_r + 16'h0001;
                end else begin
                  crcDrops_r <= crcDrops_r + 16'h0001;
                end
              end
            end
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (state_r == ST_RX && rxByteValid && !doFull && int'(rxIdx_r) >= HDR_LEN) begin
      doMem[doWr_r[DOW-1:0]] <= rxByteData;
    end
  end

  // Only committed packets are visible to the serial output
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      doRd_r         <= '0;
      serialOutValid <= 1'b0;
      serialOutData  <= 8'h00;
    end else if (shut) begin
      doRd_r         <= '0;
      serialOutValid <= 1'b0;
    end else if ((!serialOutValid || serialOutReady) && doCommit_r != doRd_r) begin
      serialOutValid <= 1'b1;
      serialOutData  <= doMem[doRd_r[DOW-1:0]];
      doRd_r         <= doRd_r + 1'b1;
    end else if (serialOutReady) begin
      serialOutValid <= 1'b0;
    end
  end

  // Hysteresis keeps the host from chattering near full
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctsN <= 1'b0;
    end else if (shut) begin
      ctsN <= 1'b0;
    end else if (diFree <= int'(flowThr_r)) begin
      ctsN <= 1'b1;
    end else if (diFree >= CTS_RESUME) begin
      ctsN <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shutLineOut         <= 1'b0;
      shutLineOe          <= 1'b0;
      ctsOe               <= 1'b1;
      carrierDetectOut    <= 1'b0;
      carrierDetectOe     <= 1'b1;
      transmitPowerOut    <= 1'b0;
      transmitPowerOe     <= 1'b1;
      receiveIndicatorOut <= 1'b0;
      receiveIndicatorOe  <= 1'b1;
      serialOutOe         <= 1'b1;
    end else begin
      shutLineOut         <= 1'b0;
      shutLineOe          <= shut;
      ctsOe               <= ~shut;
      carrierDetectOe     <= ~shut;
      transmitPowerOe     <= ~shut;
      receiveIndicatorOe  <= ~shut;
      serialOutOe         <= ~shut;
      carrierDetectOut    <= ~shut && rxActive;
      transmitPowerOut    <= ~shut && state_r inside {ST_TXINIT, ST_TXHDR, ST_TXPAY, ST_TXCRC};
      receiveIndicatorOut <= ~shut && state_r == ST_RX && rxByteValid;
    end
  end

  AST_IDLE_TO_RX: assert property (@(posedge clk) disable iff (rst)
    state_r == ST_IDLE && rxActive && !shut |=> state_r == ST_RX)
    else $error("idle did not enter receive");
  AST_NO_TX_IN_RX: assert property (@(posedge clk) disable iff (rst)
    state_r == ST_RX |=> state_r inside {ST_RX, ST_IDLE, ST_SHUT})
    else $error("transmit entered from receive");
  AST_THRESH: assert property (@(posedge clk) disable iff (rst)
    state_r == ST_IDLE && !rxActive && !shut && int'(diCount) >= int'(thr_r) && diCount != '0
    |=> state_r == ST_TXINIT)
    else $error("threshold did not start transmit");
  AST_TOUT_OFF: assert property (@(posedge clk) disable iff (rst)
    state_r == ST_IDLE && !rxActive && !shut && tout_r == '0 && int'(diCount) < int'(thr_r)
    |=> state_r == ST_IDLE)
    else $error("transmit started with timeout disabled");
  AST_INIT_FIRST: assert property (@(posedge clk) disable iff (rst)
    state_r == ST_TXINIT && canSend && !shut |=> state_r == ST_TXHDR && txValid && txKind == KIND_INIT)
    else $error("initializer missing");
  AST_STREAM: assert property (@(posedge clk) disable iff (rst)
    crcLastEmit && diCount != '0 && !shut |=> state_r == ST_TXHDR ##1 txKind != KIND_INIT || shut)
    else $error("streamed packet restarted initializer");
  AST_PKT_SIZE: assert property (@(posedge clk) disable iff (rst)
    state_r == ST_TXPAY |-> pktLeft_r <= maxPkt_r && pktLeft_r != '0)
    else $error("packet exceeds maximum size");
  AST_SHUT: assert property (@(posedge clk) disable iff (rst)
    shut |=> state_r == ST_SHUT && diCount == '0 && !txValid && !serialOutValid)
    else $error("shutdown did not abort");
  AST_PINS: assert property (@(posedge clk) disable iff (rst)
    state_r == ST_SHUT |-> !ctsOe && !serialOutOe && !carrierDetectOe && shutLineOe && !shutLineOut)
    else $error("pins not released in shutdown");
  AST_RX_END: assert property (@(posedge clk) disable iff (rst)
    state_r == ST_RX && !shut && (rxError || !rxActive) |=> state_r == ST_IDLE && doWr_r == doCommit_r)
    else $error("receive did not end");
  AST_CTS: assert property (@(posedge clk) disable iff (rst)
    !shut && diFree <= int'(flowThr_r) |=> ctsN)
    else $error("clear-to-send not deasserted near full");
endmodule

//--- tb/rmmc_radio_sink.sv
// Radio side model: accepts framed bytes with periodic stalls and records them
module rmmc_radio_sink
  import rmmc_pkg::*;
(
  input  wire logic           clk,
  input  wire logic           txValid,
  input  wire logic [7:0]     txData,
  input  rmmc_pkg::rmmc_kind_t txKind,
  output logic                txReady
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt = 2'h0;
  logic [9:0] got[$];
  initial txReady = 1'b0;
  // Stalls one cycle in four so the framer must hold its byte
  always @(posedge clk) begin
    cnt <= cnt + 2'h1;
    txReady <= (cnt != 2'h3);
    if (txValid === 1'b1 && txReady === 1'b1) got.push_back({txKind, txData});
  end
endmodule

//--- tb/radio_modem_mode_controller_tb_top.sv
// Bench: APB setup, serial stimulus, framed output and shutdown checks
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fail_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module radio_modem_mode_controller_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rmmc_pkg::*;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, sv = 0, rxA = 0, shN = 1;
  logic [7:0] paddr = 8'h00, sd = 8'h00, txData;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, err, txValid, txReady, shOut, shOe, ctsOe, soOe;
  logic rbv = 0, rbl = 0, soV, cts, cd;
  logic [7:0] rbd = 8'h00, soD;
  logic [23:0] so = 24'h000000;
  rmmc_kind_t txKind;
  logic [9:0] exq[$];
  int fail_count = 0, check_count = 0;
  initial forever #5 clk = ~clk;
  rmmc_mode_ctrl #(.DI_DEPTH(64), .DO_DEPTH(64), .CHAR_CYCLES(20)) i_rmmc_mode_ctrl (.clk(clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serialInValid(sv), .serialInData(sd), .serialOutValid(soV),
    .serialOutData(soD), .serialOutReady(1'b1), .txValid(txValid), .txData(txData), .txKind(txKind),
    .txReady(txReady), .rxActive(rxA), .rxByteValid(rbv), .rxByteData(rbd), .rxByteLast(rbl),
    .rxError(1'b0), .shutdownN(shN), .shutLineOut(shOut), .shutLineOe(shOe), .ctsN(cts), .ctsOe(ctsOe),
    .carrierDetectOut(cd), .carrierDetectOe(), .transmitPowerOut(), .transmitPowerOe(),
    .receiveIndicatorOut(), .receiveIndicatorOe(), .serialOutOe(soOe));
  rmmc_radio_sink i_rmmc_radio_sink (.clk(clk), .txValid(txValid), .txData(txData), .txKind(txKind),
    .txReady(txReady));
  // Serial output is always ready, so every valid edge is one byte
  always @(posedge clk) if (soV === 1'b1) so <= {so[15:0], soD};
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic ser(input logic [7:0] f, input int n);
    // Plain data only, never a guarded command sequence
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      sv <= 1'b1; sd <= f + 8'(i);
    end
    @(posedge clk);
    sv <= 1'b0;
  endtask
  // Radio packet in: bad[0] spoils the CRC, bad[1] the channel byte of the header
  task automatic rxp(input logic [7:0] f, input int n, input logic [1:0] bad);
    logic [15:0] c;
    logic [7:0] b[$];
    c = 16'hFFFF;
    b = '{8'h5A ^ {7'h00, bad[1]}, 8'h12, 8'h34, 8'hAB, 8'hCD};
    for (int i = 0; i < n; i++) b.push_back(f + 8'(i));
    foreach (b[i]) c = crc(c, b[i]);
    b.push_back(c[15:8]);
    b.push_back(c[7:0] ^ {7'h00, bad[0]});
    foreach (b[i]) begin
      @(posedge clk);
      rbv <= 1'b1; rbd <= b[i]; rbl <= (i == b.size() - 1);
    end
    @(posedge clk);
    rbv <= 1'b0; rbl <= 1'b0;
  endtask
  function automatic logic [15:0] crc(input logic [15:0] c, input logic [7:0] d);
    for (int i = 7; i >= 0; i--) c = (c[15] ^ d[i]) ? ((c << 1) ^ 16'h1021) : (c << 1);
    return c;
  endfunction
  // Expected frame: optional initializer, header, payload f.., CRC high byte first
  task automatic pk(input bit ini, input logic [7:0] f, input int n);
    logic [15:0] c;
    logic [7:0] h[5];
    c = 16'hFFFF;
    h = '{8'h5A, 8'h12, 8'h34, 8'hAB, 8'hCD};
    if (ini) exq.push_back({2'h0, 8'h5A});
    for (int i = 0; i < 5; i++) begin exq.push_back({2'h1, h[i]}); c = crc(c, h[i]); end
    for (int i = 0; i < n; i++) begin exq.push_back({2'h2, f + 8'(i)}); c = crc(c, f + 8'(i)); end
    exq.push_back({2'h3, c[15:8]});
    exq.push_back({2'h3, c[7:0]});
  endtask
  task automatic drain();
    for (int i = 0; i < 3000 && i_rmmc_radio_sink.got.size() < exq.size(); i++) @(posedge clk);
    repeat (20) @(posedge clk);
    `CHK(i_rmmc_radio_sink.got.size(), exq.size())
    foreach (exq[i]) `CHK(i_rmmc_radio_sink.got[i], exq[i])
    exq.delete();
    i_rmmc_radio_sink.got.delete();
  endtask
  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #200us;
    fail_count++;
    stop_test();
  end
  initial begin
    logic [31:0] rv[5];
    rv = '{32'h800, 32'h3, 32'h800, 32'hFFFF, 32'h11};
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    foreach (rv[i]) begin apb(0, (i < 3) ? 8'(4 * i) : 8'(4 * i + 8), 0); `CHK(q, rv[i]) end
    apb(0, 8'h24, 0); `CHK(err, 1'b1)
    // Threshold kept within one and the packet size
    apb(1, OFF_THR, 2); apb(1, OFF_TOUT, 0); apb(1, OFF_MAXPKT, 2);
    apb(1, OFF_HOPCH, 8'h5A); apb(1, OFF_NETID, 16'h1234); apb(1, OFF_DSTADDR, 16'hABCD);
    // Reception in progress holds the pending bytes back
    rxA <= 1'b1;
    ser(8'h40, 4);
    repeat (30) @(posedge clk);
    `CHK(i_rmmc_radio_sink.got.size(), 0)
    apb(0, OFF_STATUS, 0); `CHK(q, 32'h2000_0004)
    rxA <= 1'b0;
    pk(1, 8'h40, 2); pk(0, 8'h42, 2); drain();
    apb(0, OFF_STATUS, 0); `CHK(q, 32'h0100_0000)
    // Silence of two characters sends a single byte below the threshold
    apb(1, OFF_MAXPKT, 40); apb(1, OFF_THR, 40); apb(1, OFF_TOUT, 2);
    ser(8'h77, 1);
    pk(1, 8'h77, 1); drain();
    // Shutdown mid-buffer floats the pins and empties the input buffer
    ser(8'h10, 1);
    shN <= 1'b0;
    repeat (6) @(posedge clk);
    `CHK({ctsOe, soOe, shOe, shOut}, 4'b0010)
    shN <= 1'b1;
    repeat (6) @(posedge clk);
    apb(0, OFF_STATUS, 0); `CHK(q, 32'h0100_0000)
    `CHK(i_rmmc_radio_sink.got.size(), 0)
    // Good, corrupted and foreign packets, then serial bytes pile up behind reception
    rxA <= 1'b1;
    rxp(8'h60, 3, 2'b00); rxp(8'h70, 2, 2'b01); rxp(8'h50, 1, 2'b10);
    ser(8'h00, 48);
    repeat (4) @(posedge clk);
    `CHK(so, 24'h606162)
    `CHK({cts, cd}, 2'b11)
    apb(0, OFF_DROPS, 0); `CHK(q, 32'h0001_0001)
    rxA <= 1'b0;
    pk(1, 8'h00, 40); pk(0, 8'h28, 8); drain();
    `CHK(cts, 1'b0)
    stop_test();
  end
endmodule
